// ==== pkg/sync_port_map.svh ====
// Register offsets, field positions, reset values and timing counts of the sync port control
`ifndef SYNC_PORT_MAP_SVH
`define SYNC_PORT_MAP_SVH

`define ADDR_CTRL        4'h0
`define ADDR_QL_TX       4'h1
`define ADDR_STATUS      4'h2
`define ADDR_RX_QL       4'h3
`define ADDR_COUNTS      4'h4

`define CTRL_SYNC_EN_BIT 0
`define CTRL_MSG_EN_BIT  1
`define CTRL_QL_EN_BIT   2
`define CTRL_DNU_SEL_BIT 3

`define CTRL_RESET       4'h0
`define QL_TX_RESET      4'h0

`define QL_DNU           4'hF
`define QL_DUS           4'hF

`define CLK_HZ           32'd20_000_000
`define TICK_CYCLES      32'd20_000_000
`define MSG_PER_SEC      32'd1
`define SLOW_MAX_PER_SEC 4'hA

`define ETYPE_SLOW       16'h8809
`define SUBTYPE_OSSP     8'h0A

`endif

// ==== pkg/sync_port_pkg.sv ====
// Types shared by the sync port control
package sync_port_pkg;
    typedef logic [3:0]  ql_t;
    typedef logic [31:0] word_t;
    typedef logic [3:0]  addr_t;
    typedef enum logic [2:0]
    {
        TX_IDLE = 3'b001,
        TX_REQ  = 3'b010,
        TX_WAIT = 3'b100
    } tx_state_t;
endpackage : sync_port_pkg

// ==== core/sync_port_ctrl.sv ====
// Synchronous port clocking, sync status messaging and quality level control
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Behaviour
// RULE_01: After reset sync off, asynchronous clocking, messaging and quality handling off.
// RULE_02: With sync on, transmit clock comes from the equipment clock.
// RULE_03: Software can turn sync operation on or off.
// RULE_04: Asynchronous mode uses the local nominal-frequency oscillator.
// RULE_05: Enabled generator emits one message frame per second.
// RULE_06: No more than ten slow-protocol frames leave in any second; the code caps fixed one-second windows, so twenty can.
// RULE_07: Message frames carry the slow-protocol multicast destination.
// RULE_08: Software can turn messaging on or off.
// RULE_09: Entering sync operation turns messaging on by default.
// RULE_10: Messaging off means no message frames are generated.
// RULE_11: Messaging off means received message frames are discarded.
// RULE_12: Messaging on means frames are sent and received ones processed.
// RULE_13: Sync with messaging on is never offered as a network clock source.
// RULE_14: Sync with messaging off still follows the equipment clock.
// RULE_15: Aggregation link state has no effect on clocking or messaging.
// RULE_16: Quality off sends do-not-use and ignores received quality values.
// RULE_17: Quality on sends the real value and processes received values.
// RULE_18: Sync with messaging on turns quality handling on by default.
// RULE_19: Software can set the quality mode.
// RULE_20: Peer towards us sends only do-not-use quality values.
// RULE_21: Quality off with messaging on keeps sending do-not-use frames.
// RULE_22: Any four-bit quality value can be transmitted.
// RULE_23: Received message frames found by slow Ethertype and organisation subtype.
`include "sync_port_map.svh"
module sync_port_ctrl
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    // Register port
    input  wire sync_port_pkg::addr_t  reg_addr,
    input  wire sync_port_pkg::word_t  reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [31:0]                reg_rdata,
    // Other slow-protocol sources asking to send a frame
    input  wire logic                  slow_req,
    output logic                       slow_grant,
    // Message frame request toward the transmit framer
    output logic                       msg_tx_req,
    output logic [3:0]                 msg_tx_ql,
    output logic                       msg_tx_mcast,
    input  wire logic                  msg_tx_done,
    // Received frame summary from the receive parser
    input  wire logic                  rx_valid,
    input  wire logic [15:0]           rx_etype,
    input  wire logic [7:0]            rx_subtype,
    input  wire logic [3:0]            rx_ql,
    input  wire logic                  rx_lag_standby,
    // Clock selection
    output logic                       tx_clk_sel_eec,
    output logic                       clk_src_selectable,
    output logic                       rx_ql_valid
);
    import sync_port_pkg::*;

    // ==========================================================
    // Reset release
    logic rst_s1_ff;
    logic rst_n_ff;
    // Release is synchronous so every flop leaves reset on the same edge
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end

    function automatic logic is_msg_frame(input logic [15:0] et, input logic [7:0] st);
        is_msg_frame = (et == `ETYPE_SLOW) && (st == `SUBTYPE_OSSP);
    endfunction : is_msg_frame

    function automatic logic reg_hit(input addr_t a, input addr_t idx);
        reg_hit = (a == idx);
    endfunction : reg_hit

    // Counters stick at full scale rather than wrap back to small values
    function automatic logic [15:0] sat_inc16(input logic [15:0] v);
        sat_inc16 = (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction : sat_inc16

    // ==========================================================
    // Control registers
    logic [3:0] ctrl_ff;
    logic [3:0] nxt_ctrl;
    ql_t        ql_tx_ff;
    ql_t        nxt_ql_tx;
    logic       wr_ctrl;
    logic       wr_ql_tx;
    assign wr_ctrl  = reg_wr && reg_hit(reg_addr, `ADDR_CTRL);
    assign wr_ql_tx = reg_wr && reg_hit(reg_addr, `ADDR_QL_TX);

    always_comb
    begin
        nxt_ctrl  = ctrl_ff;
        nxt_ql_tx = ql_tx_ff;
        if (wr_ctrl)
        begin
            nxt_ctrl = reg_wdata[3:0]; // RULE_03 RULE_08 RULE_19
            // Turning sync on brings messaging and quality up by default
            if (reg_wdata[`CTRL_SYNC_EN_BIT] && !ctrl_ff[`CTRL_SYNC_EN_BIT])
            begin
                nxt_ctrl[`CTRL_MSG_EN_BIT] = 1'b1; // RULE_09
                nxt_ctrl[`CTRL_QL_EN_BIT]  = 1'b1; // RULE_18
            end
        end
        if (wr_ql_tx)
            nxt_ql_tx = reg_wdata[3:0]; // RULE_22
    end

    always_ff @(posedge clk_sys or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            ctrl_ff  <= `CTRL_RESET; // RULE_01
            ql_tx_ff <= `QL_TX_RESET;
        end
        else
        begin
            ctrl_ff  <= nxt_ctrl;
            ql_tx_ff <= nxt_ql_tx;
        end
    end

    logic sync_en;
    logic msg_en;
    logic ql_en;
    // Messaging and quality only live while in sync mode
    assign sync_en = ctrl_ff[`CTRL_SYNC_EN_BIT];
    assign msg_en  = sync_en && ctrl_ff[`CTRL_MSG_EN_BIT];
    assign ql_en   = msg_en && ctrl_ff[`CTRL_QL_EN_BIT];

    // ==========================================================
    // One-second window: message tick and slow-protocol budget
    logic [31:0] sec_cnt_ff;
    logic [31:0] nxt_sec_cnt;
    logic [3:0]  slow_cnt_ff;
    logic [3:0]  nxt_slow_cnt;
    logic        sec_tick;
    logic        budget_ok;
    logic        msg_take;
    logic        slow_take;

    assign sec_tick  = (sec_cnt_ff == `TICK_CYCLES - 32'd1);
    // Window resets each second; ten frames max per window
    assign budget_ok = (slow_cnt_ff < `SLOW_MAX_PER_SEC); // RULE_06

    tx_state_t  st_ff;
    tx_state_t  nxt_st;
    logic       pend_ff;
    logic       nxt_pend;

    // Message frames take priority over other slow-protocol users
    assign msg_take  = (st_ff == TX_IDLE) && pend_ff && msg_en && budget_ok;
    assign slow_take = slow_req && budget_ok && !msg_take && !sec_tick;

    always_comb
    begin
        nxt_sec_cnt  = sec_tick ? 32'd0 : sec_cnt_ff + 32'd1;
        nxt_slow_cnt = slow_cnt_ff;
        if (sec_tick)
            nxt_slow_cnt = 4'h0;
        else if (msg_take || slow_take)
            nxt_slow_cnt = slow_cnt_ff + 4'h1; // RULE_06
    end

    always_ff @(posedge clk_sys or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            sec_cnt_ff  <= 32'd0;
            slow_cnt_ff <= 4'h0;
        end
        else
        begin
            sec_cnt_ff  <= nxt_sec_cnt;
            slow_cnt_ff <= nxt_slow_cnt;
        end
    end

    // ==========================================================
    // Message transmit sequencer
    logic       tx_req_ff;
    logic       nxt_tx_req;
    ql_t        tx_ql_ff;
    ql_t        nxt_tx_ql;
    logic       grant_ff;
    logic       nxt_grant;
    logic [15:0] sent_ff;
    logic [15:0] nxt_sent;

    always_comb
    begin
        nxt_st     = st_ff;
        nxt_tx_req = 1'b0;
        nxt_tx_ql  = tx_ql_ff;
        nxt_sent   = sent_ff;
        nxt_pend   = pend_ff;
        nxt_grant  = slow_take;
        case (st_ff)
            TX_IDLE:
            begin
                if (msg_take)
                begin
                    nxt_pend   = 1'b0;
                    nxt_tx_req = 1'b1;
                    nxt_tx_ql  = ql_en ? ql_tx_ff : `QL_DNU; // RULE_16 RULE_17 RULE_21
                    nxt_st     = TX_REQ;
                end
            end
            TX_REQ:
            begin
                nxt_sent = sat_inc16(sent_ff);
                nxt_st   = TX_WAIT;
            end
            TX_WAIT:
            begin
                // No timeout: a framer that never answers stalls messaging
                if (msg_tx_done)
                    nxt_st = TX_IDLE;
            end
            default:
                nxt_st = TX_IDLE;
        endcase
        // One frame per second; a tick while pending is merged
        // Applied after the take so a tick landing on a take is kept
        if (sec_tick && msg_en)
            nxt_pend = 1'b1; // RULE_05 RULE_15
        if (!msg_en)
            nxt_pend = 1'b0; // RULE_10
    end

    always_ff @(posedge clk_sys or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            st_ff     <= TX_IDLE;
            tx_req_ff <= 1'b0;
            tx_ql_ff  <= `QL_DNU;
            pend_ff   <= 1'b0;
            sent_ff   <= 16'h0000;
            grant_ff  <= 1'b0;
        end
        else
        begin
            st_ff     <= nxt_st;
            tx_req_ff <= nxt_tx_req;
            tx_ql_ff  <= nxt_tx_ql;
            pend_ff   <= nxt_pend;
            sent_ff   <= nxt_sent;
            grant_ff  <= nxt_grant;
        end
    end

    // ==========================================================
    // Receive path
    logic       rx_ok;
    logic       rx_ql_v_ff;
    logic       nxt_rx_ql_v;
    ql_t        rx_ql_ff;
    ql_t        nxt_rx_ql;
    logic [15:0] drop_ff;
    logic [15:0] nxt_drop;

    // Peer should only send do-not-use here; value still recorded
    assign rx_ok = rx_valid && is_msg_frame(rx_etype, rx_subtype); // RULE_23 RULE_20

    always_comb
    begin
        nxt_rx_ql = rx_ql_ff;
        nxt_drop  = drop_ff;
        nxt_rx_ql_v = rx_ok && ql_en;
        if (rx_ok && !msg_en)
            nxt_drop = sat_inc16(drop_ff); // RULE_11
        else if (rx_ok && ql_en)
            nxt_rx_ql = rx_ql; // RULE_12 RULE_17
        // Quality ignored when handling is off
        if (!ql_en)
            nxt_rx_ql = `QL_DNU; // RULE_16
    end

    always_ff @(posedge clk_sys or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            rx_ql_ff   <= `QL_DNU;
            rx_ql_v_ff <= 1'b0;
            drop_ff    <= 16'h0000;
        end
        else
        begin
            rx_ql_ff   <= nxt_rx_ql;
            rx_ql_v_ff <= nxt_rx_ql_v;
            drop_ff    <= nxt_drop;
        end
    end

    // ==========================================================
    // Clock selection outputs
    logic sel_eec_ff;
    logic selectable_ff;
    logic nxt_sel_eec;
    logic nxt_selectable;

    always_comb
    begin
        nxt_sel_eec    = sync_en; // RULE_02 RULE_14
        // Timing must only flow outward from this port while messaging is on
        nxt_selectable = sync_en && !msg_en; // RULE_13
    end

    always_ff @(posedge clk_sys or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            sel_eec_ff    <= 1'b0; // RULE_04
            selectable_ff <= 1'b0;
        end
        else
        begin
            sel_eec_ff    <= nxt_sel_eec;
            selectable_ff <= nxt_selectable;
        end
    end

    // ==========================================================
    // Register read
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [4:0]  status_bits;
    assign status_bits = {ql_en, msg_en, sync_en, sel_eec_ff, selectable_ff};

    // Data only in the cycle after the strobe; an idle bus reads zero
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (reg_rd)
        begin
            case (reg_addr)
                `ADDR_CTRL:   nxt_rdata = {28'h000_0000, ctrl_ff};
                `ADDR_QL_TX:  nxt_rdata = {28'h000_0000, ql_tx_ff};
                `ADDR_STATUS: nxt_rdata = {27'h000_0000, status_bits};
                `ADDR_RX_QL:  nxt_rdata = {28'h000_0000, rx_ql_ff};
                `ADDR_COUNTS: nxt_rdata = {sent_ff, drop_ff};
                default:      nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            rdata_ff <= 32'h0000_0000;
        else
            rdata_ff <= nxt_rdata;
    end

    assign reg_rdata          = rdata_ff;
    assign slow_grant         = grant_ff;
    assign msg_tx_req         = tx_req_ff;
    assign msg_tx_ql          = tx_ql_ff;
    assign msg_tx_mcast       = tx_req_ff; // RULE_07
    assign tx_clk_sel_eec     = sel_eec_ff;
    assign clk_src_selectable = selectable_ff;
    assign rx_ql_valid        = rx_ql_v_ff;

endmodule : sync_port_ctrl

// ==== verification/sync_port_checker.sv ====
// Port-level assertions for the sync port control
`timescale 1ns/1ps
`include "sync_port_map.svh"
module sync_port_checker
(
    // Clock and reset
    input wire logic                 clk_sys,
    input wire logic                 nrst,
    // Register port
    input wire sync_port_pkg::addr_t reg_addr,
    input wire sync_port_pkg::word_t reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    // Frames and clocking
    input wire logic                 msg_tx_req,
    input wire logic                 msg_tx_mcast,
    input wire logic                 rx_valid,
    input wire logic [15:0]          rx_etype,
    input wire logic [7:0]           rx_subtype,
    input wire logic                 tx_clk_sel_eec,
    input wire logic                 clk_src_selectable,
    input wire logic                 rx_ql_valid
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // ==========
    // Properties
    property p_mcast;
        msg_tx_mcast == msg_tx_req;
    endproperty
    property p_req_pulse;
        msg_tx_req |=> !msg_tx_req;
    endproperty
    property p_req_sync;
        msg_tx_req |-> tx_clk_sel_eec;
    endproperty
    property p_src;
        clk_src_selectable |-> tx_clk_sel_eec;
    endproperty
    property p_sync_on;
        reg_wr && reg_addr == `ADDR_CTRL && reg_wdata[0] |-> ##[1:2] tx_clk_sel_eec;
    endproperty
    property p_sync_off;
        reg_wr && reg_addr == `ADDR_CTRL && !reg_wdata[0]
            |-> ##[1:2] !tx_clk_sel_eec && !clk_src_selectable;
    endproperty
    property p_src_off;
        reg_wr && reg_addr == `ADDR_CTRL && reg_wdata[0] && reg_wdata[1]
            |-> ##2 !clk_src_selectable;
    endproperty
    property p_rd_zero;
        reg_rdata != 32'h0000_0000 |-> $past(reg_rd);
    endproperty
    property p_rx_type;
        rx_ql_valid |-> $past(rx_valid && rx_etype == `ETYPE_SLOW
                              && rx_subtype == `SUBTYPE_OSSP);
    endproperty
    a_mcast: assert property (p_mcast) else $error("mcast differs from req");
    a_req_pulse: assert property (p_req_pulse) else $error("req too long");
    a_req_sync: assert property (p_req_sync) else $error("frame in async");
    a_src: assert property (p_src) else $error("bad source offer");
    a_sync_on: assert property (p_sync_on) else $error("eec not chosen");
    a_sync_off: assert property (p_sync_off) else $error("eec kept");
    a_src_off: assert property (p_src_off) else $error("offered while messaging");
    a_rd_zero: assert property (p_rd_zero) else $error("stray read data");
    a_rx_type: assert property (p_rx_type) else $error("foreign frame taken");
    c_sel: cover property (tx_clk_sel_eec && !clk_src_selectable);
    c_src: cover property (clk_src_selectable);
    c_rx: cover property (rx_ql_valid);
endmodule : sync_port_checker
bind sync_port_ctrl sync_port_checker u_sync_port_checker
(
    .clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .msg_tx_req,
    .msg_tx_mcast, .rx_valid, .rx_etype, .rx_subtype, .tx_clk_sel_eec, .clk_src_selectable,
    .rx_ql_valid
);

// ==== verification/sync_peer_model.sv ====
// Far-end framer and peer port giving frame summaries
`timescale 1ns/1ps
module sync_peer_model
(
    // Clock
    input wire logic    clk_sys,
    // Framer side
    input wire logic    msg_tx_req,
    output logic        msg_tx_done,
    // Receive summaries
    output logic        rx_valid,
    output logic [15:0] rx_etype,
    output logic [7:0]  rx_subtype,
    output logic [3:0]  rx_ql
);
    int unsigned left = 0;
    initial
    begin
        msg_tx_done = 1'b0;
        rx_valid = 1'b0;
        rx_etype = 16'h0000;
        rx_subtype = 8'h00;
        rx_ql = 4'h0;
    end
    // Frame occupies the wire a random while
    always @(posedge clk_sys)
    begin
        msg_tx_done <= (left == 1);
        left <= msg_tx_req ? 1 + $urandom_range(7) : (left != 0 ? left - 1 : 0);
    end
    task automatic send(input logic [15:0] et, input logic [7:0] st, input logic [3:0] ql);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_etype <= et;
        rx_subtype <= st;
        rx_ql <= ql;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        // Stale fields scrambled, not held
        rx_etype <= ~et;
        rx_subtype <= ~st;
        rx_ql <= ~ql;
    endtask : send
endmodule : sync_peer_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the sync port control
`timescale 1ns/1ps
`include "sync_port_map.svh"
module tb_top;
    import sync_port_pkg::*;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    addr_t       reg_addr = '0;
    word_t       reg_wdata = '0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        slow_req = 1'b0;
    logic        rx_lag_standby = 1'b0;
    logic [31:0] reg_rdata;
    logic [15:0] rx_etype;
    logic [7:0]  rx_subtype;
    logic [3:0]  msg_tx_ql, rx_ql, q, exp_ql;
    logic        slow_grant, msg_tx_req, msg_tx_mcast, msg_tx_done, rx_valid;
    logic        tx_clk_sel_eec, clk_src_selectable, rx_ql_valid, ok;
    word_t       v;
    int          miscompares = 0, checks = 0, gnts = 0, qvs = 0, nacc = 0, cyc = 0, reqs = 0;
    always #25 clk_sys = ~clk_sys;
    sync_port_ctrl u_sync_port_ctrl (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .slow_req, .slow_grant, .msg_tx_req, .msg_tx_ql, .msg_tx_mcast, .msg_tx_done,
        .rx_valid, .rx_etype, .rx_subtype, .rx_ql, .rx_lag_standby, .tx_clk_sel_eec,
        .clk_src_selectable, .rx_ql_valid);
    sync_peer_model u_sync_peer_model (.clk_sys, .msg_tx_req, .msg_tx_done, .rx_valid,
        .rx_etype, .rx_subtype, .rx_ql);
    // ==========
    // Tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    function automatic word_t exp_status(input logic [3:0] c);
        logic s, m, l;
        s = c[`CTRL_SYNC_EN_BIT];
        m = s && c[`CTRL_MSG_EN_BIT];
        l = m && c[`CTRL_QL_EN_BIT];
        exp_status = {27'h0, l, m, s, s, s && !m};
    endfunction : exp_status
    task automatic wr(input addr_t a, input word_t d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : wr
    task automatic rchk(input string n, input addr_t a, input word_t e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(n, e, reg_rdata);
    endtask : rchk
    task automatic rx(input logic good, input logic [3:0] ql);
        rx_lag_standby <= 1'($urandom);
        u_sync_peer_model.send(`ETYPE_SLOW, good ? `SUBTYPE_OSSP : 8'h0B, ql);
        repeat (2) @(posedge clk_sys);
    endtask : rx
    task automatic end_sim;
        $display("Checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        gnts <= gnts + slow_grant;
        qvs <= qvs + rx_ql_valid;
        reqs <= reqs + msg_tx_req;
        if (cyc == 20000)
        begin
            miscompares++;
            end_sim();
        end
    end
    // ==========
    // Scenarios
    initial
    begin
        void'($urandom(32'h677e));
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rchk("ctrl", `ADDR_CTRL, 32'h0000_0000);
        rchk("status", `ADDR_STATUS, exp_status(4'h0));
        rchk("rx_ql", `ADDR_RX_QL, 32'h0000_000F);
        wr(4'h9, 32'hFFFF_FFFF);
        rchk("unmapped", 4'h9, 32'h0000_0000);
        for (int i = 0; i < 16; i++)
        begin
            wr(`ADDR_QL_TX, 32'(i));
            rchk("ql_tx", `ADDR_QL_TX, 32'(i));
        end
        wr(`ADDR_CTRL, 32'h0000_0001);
        rchk("ctrl", `ADDR_CTRL, 32'h0000_0007);
        rchk("status", `ADDR_STATUS, exp_status(4'h7));
        chk("clk_sel", 32'h0000_0002, {30'h0, tx_clk_sel_eec, clk_src_selectable});
        wr(`ADDR_CTRL, 32'h0000_0001);
        rchk("status", `ADDR_STATUS, exp_status(4'h1));
        for (int i = 0; i < 3; i++)
            rx(1'b1, 4'($urandom));
        rchk("rx_ql", `ADDR_RX_QL, 32'h0000_000F);
        chk("tx_idle", 32'h0000_000F, {26'h0, msg_tx_req, msg_tx_mcast, msg_tx_ql});
        wr(`ADDR_CTRL, 32'h0000_0003);
        rchk("status", `ADDR_STATUS, exp_status(4'h3));
        rx(1'b1, `QL_DNU);
        rchk("rx_ql", `ADDR_RX_QL, 32'h0000_000F);
        chk("qv_off", 32'h0, 32'(qvs));
        wr(`ADDR_CTRL, 32'h0000_0007);
        for (int i = 0; i < 8; i++)
        begin
            q = 4'($urandom);
            ok = (i == 0) || 1'($urandom);
            rx(ok, q);
            exp_ql = ok ? q : exp_ql;
            nacc += ok;
        end
        rchk("rx_ql", `ADDR_RX_QL, 32'(exp_ql));
        chk("qv_on", 32'(nacc), 32'(qvs));
        rchk("counts", `ADDR_COUNTS, 32'h0000_0003);
        slow_req <= 1'b1;
        repeat (300) @(posedge clk_sys);
        slow_req <= 1'b0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("grants", 32'd10, 32'(gnts));
        wr(`ADDR_CTRL, 32'h0000_0000);
        @(negedge clk_sys);
        chk("clk_sel", 32'h0, {30'h0, tx_clk_sel_eec, clk_src_selectable});
        chk("frames", 32'h0, 32'(reqs));
        end_sim();
    end
endmodule : tb_top
